// File: rtl/fimfl_pkg.sv
// Shared constants and types for the interrupt mask and queue level block
package fimfl_pkg;

  // Register addresses on the serial register port
  localparam logic [4:0] ADDR_DATA_A   = 5'h00;
  localparam logic [4:0] ADDR_DATA_B   = 5'h01;
  localparam logic [4:0] ADDR_EVENTS   = 5'h02;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h03;
  localparam logic [4:0] ADDR_LVL_A    = 5'h04;
  localparam logic [4:0] ADDR_LVL_B    = 5'h05;
  localparam logic [4:0] ADDR_LINE_A   = 5'h06;

  // Reset values
  localparam logic [7:0] IRQ_MASK_RST  = 8'h00;
  localparam logic [7:0] LVL_A_RST     = 8'h01;
  localparam logic [7:0] LVL_B_RST     = 8'h00;
  localparam logic [7:0] LINE_A_RST    = 8'h00;
  localparam logic [7:0] EVENTS_RST    = 8'h00;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // Event bits that clear when the event register is read
  localparam logic [7:0] EVT_CLR_ON_READ = 8'hFC;

  // Event and mask bit positions
  localparam int BIT_SUPPLY = 7;
  localparam int BIT_WAKE   = 6;
  localparam int BIT_TXF_B  = 5;
  localparam int BIT_TXF_A  = 4;
  localparam int BIT_RXF_B  = 3;
  localparam int BIT_RXF_A  = 2;
  localparam int BIT_AVL_B  = 1;
  localparam int BIT_AVL_A  = 0;

  // Line A control fields
  localparam int RATE_HI    = 7;
  localparam int RATE_LO    = 6;
  localparam int LINK_SETUP = 5;
  localparam int AUX_HI     = 4;

  // Line A data rate codes and their rates in units of 0.1 kbps
  localparam logic [1:0]  RATE_FAIL    = 2'h0;
  localparam logic [1:0]  RATE_COM1    = 2'h1;
  localparam logic [1:0]  RATE_COM2    = 2'h2;
  localparam logic [1:0]  RATE_COM3    = 2'h3;
  localparam logic [11:0] KBPS10_COM1  = 12'h030;
  localparam logic [11:0] KBPS10_COM2  = 12'h180;
  localparam logic [11:0] KBPS10_COM3  = 12'h900;

  // Serial frame layout
  localparam int         CMD_WRITE_BIT = 7;
  localparam logic [3:0] SPI_LAST_BIT  = 4'h7;
  localparam logic [3:0] SPI_CNT_ZERO  = 4'h0;

  // Receive queue geometry
  localparam int         RXQ_DEPTH     = 64;
  localparam int         RXQ_PTR_W     = 6;
  localparam logic [6:0] RXQ_ROOM_ONE  = 7'h3F;
  localparam logic [6:0] RXQ_ROOM_TWO  = 7'h3E;

  typedef enum logic [3:0] {
    SPI_IDLE = 4'b0001,
    SPI_CMD  = 4'b0010,
    SPI_DATA = 4'b0100,
    SPI_HOLD = 4'b1000
  } fimfl_spi_state_t;

endpackage : fimfl_pkg

// File: rtl/fimfl_rxq_if.sv
// Connection between the register block and one receive queue
`timescale 1ns/1ps
`default_nettype none
interface fimfl_rxq_if;
  logic       push;
  logic [7:0] pushData;
  logic       msgDone;
  logic       pop;
  logic [7:0] popData;
  logic [7:0] level;
  logic       empty;

  modport queue (input push, pushData, msgDone, pop,
                 output popData, level, empty);
  modport user  (output push, pushData, msgDone, pop,
                 input popData, level, empty);
endinterface : fimfl_rxq_if
`default_nettype wire

// File: rtl/fimfl_rx_queue.sv
// Receive queue with a length byte placed ahead of each message
`timescale 1ns/1ps
`default_nettype none
module fimfl_rx_queue
  import fimfl_pkg::*;
(
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  rst_n,
  // Queue port
  fimfl_rxq_if.queue q
);

  logic [7:0]           mem [RXQ_DEPTH];
  logic [RXQ_DEPTH-1:0] hdrMark_ff,  nxt_hdrMark;
  logic [RXQ_PTR_W-1:0] wrPtr_ff,    nxt_wrPtr;
  logic [RXQ_PTR_W-1:0] rdPtr_ff,    nxt_rdPtr;
  logic [RXQ_PTR_W-1:0] hdrPtr_ff,   nxt_hdrPtr;
  logic [RXQ_PTR_W:0]   used_ff,     nxt_used;
  logic [7:0]           level_ff,    nxt_level;
  logic [7:0]           msgCnt_ff,   nxt_msgCnt;
  logic                 inMsg_ff,    nxt_inMsg;
  logic [RXQ_PTR_W-1:0] dataPtr;
  logic [RXQ_PTR_W:0]   addAmt;
  logic [RXQ_PTR_W:0]   subAmt;
  logic                 doPush;
  logic                 doPop;
  logic                 popHdr;

  function automatic logic [RXQ_PTR_W-1:0] fimfl_inc_ptr(
    input logic [RXQ_PTR_W-1:0] p);
    return RXQ_PTR_W'(p + 1'b1);
  endfunction : fimfl_inc_ptr

  assign q.popData = mem[rdPtr_ff];
  assign q.level   = level_ff;
  assign q.empty   = (used_ff == '0);

  // Next pointers, counts and header marks
  always_comb begin
    doPop   = q.pop && (used_ff != '0);
    popHdr  = hdrMark_ff[rdPtr_ff];
    // A new message needs room for its length byte as well
    doPush  = q.push && (inMsg_ff ? (used_ff <= RXQ_ROOM_ONE)
                                  : (used_ff <= RXQ_ROOM_TWO));
    dataPtr = inMsg_ff ? wrPtr_ff : fimfl_inc_ptr(wrPtr_ff);
    addAmt  = doPush ? (inMsg_ff ? 7'h01 : 7'h02) : 7'h00;
    subAmt  = doPop ? 7'h01 : 7'h00;
    nxt_used    = RXQ_PTR_W'(used_ff + addAmt - subAmt) == '0 && 1'b0
                  ? '0 : (RXQ_PTR_W+1)'(used_ff + addAmt - subAmt);
    nxt_wrPtr   = doPush ? fimfl_inc_ptr(dataPtr) : wrPtr_ff;
    nxt_rdPtr   = doPop ? fimfl_inc_ptr(rdPtr_ff) : rdPtr_ff;
    nxt_hdrPtr  = (doPush && !inMsg_ff) ? wrPtr_ff : hdrPtr_ff;
    // Level counts message bytes only, never length bytes
    nxt_level   = 8'(level_ff + {7'h00, doPush}
                  - {7'h00, doPop && !popHdr});
    nxt_msgCnt  = doPush ? (inMsg_ff ? 8'(msgCnt_ff + 1'b1) : 8'h01)
                         : msgCnt_ff;
    nxt_inMsg   = q.msgDone ? 1'b0 : (doPush ? 1'b1 : inMsg_ff);
    if (q.msgDone) begin
      nxt_msgCnt = BYTE_ZERO;
    end
    nxt_hdrMark = hdrMark_ff;
    if (doPop) begin
      nxt_hdrMark[rdPtr_ff] = 1'b0;
    end
    if (doPush && !inMsg_ff) begin
      nxt_hdrMark[wrPtr_ff] = 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hdrMark_ff <= '0;
      wrPtr_ff   <= '0;
      rdPtr_ff   <= '0;
      hdrPtr_ff  <= '0;
      used_ff    <= '0;
      level_ff   <= BYTE_ZERO;
      msgCnt_ff  <= BYTE_ZERO;
      inMsg_ff   <= 1'b0;
    end else begin
      hdrMark_ff <= nxt_hdrMark;
      wrPtr_ff   <= nxt_wrPtr;
      rdPtr_ff   <= nxt_rdPtr;
      hdrPtr_ff  <= nxt_hdrPtr;
      used_ff    <= nxt_used;
      level_ff   <= nxt_level;
      msgCnt_ff  <= nxt_msgCnt;
      inMsg_ff   <= nxt_inMsg;
    end
  end

  // Storage: data bytes, then the length byte when the message ends
  always_ff @(posedge clock) begin
    if (doPush) begin
      mem[dataPtr] <= q.pushData;
    end
    if (q.msgDone && (inMsg_ff || doPush)) begin
      mem[nxt_hdrPtr] <= nxt_msgCnt == BYTE_ZERO ? 8'(msgCnt_ff
                         + {7'h00, doPush && inMsg_ff}) : nxt_msgCnt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  level_rise_a : assert property ((doPush && !doPop) |=>
    level_ff == 8'($past(level_ff) + 1'b1))
    else $error("queue level did not count an arriving byte");
  header_skip_a : assert property ((doPop && popHdr && !doPush) |=>
    level_ff == $past(level_ff))
    else $error("queue level counted a length byte");

endmodule : fimfl_rx_queue
`default_nettype wire

// File: rtl/fimfl_top.sv
// Interrupt mask, receive queue levels and line A control registers
// How it works
// - Supply fault event drives the interrupt only while mask bit 7 is set.
// - Wake-up completion drives the interrupt only while mask bit 6 is set.
// - Channel B transmit fault reaches the interrupt only with mask bit 5.
// - Channel A transmit fault reaches the interrupt only with mask bit 4.
// - Receive faults reach the interrupt via mask bit 3 (B) and 2 (A).
// - Receive fault pins follow their events whatever the mask bits hold.
// - Data ready events reach the interrupt via mask bit 1 (B) and 0 (A).
// - Data ready pins follow their events whatever the mask bits hold.
// - Each level register shows its queue's message byte count a clock late; level A resets to 01.
// - A length byte heads each message and is left out of the level.
// - Bits 7:6 of line A control choose the line A data rate.
// - Successful link setup writes the detected rate into line A rate.
// - Rate codes: 00 failure at 230.4k, 01 4.8k, 10 38.4k, 11 230.4k.
// - Data ready sets when a queue leaves empty, clears on data read.
`timescale 1ns/1ps
`default_nettype none
module fimfl_top
  import fimfl_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Serial register port
  input  wire logic        spiClk,
  input  wire logic        spiSelN,
  input  wire logic        spiMosi,
  output logic             spiMiso,
  output logic             spiMisoOeN,
  // Open-drain interrupt request
  output logic             irqOut,
  output logic             irqOeN,
  // Event sources
  input  wire logic        supplyFaultEvent,
  input  wire logic        txFaultEventA,
  input  wire logic        txFaultEventB,
  input  wire logic        rxFaultEventA,
  input  wire logic        rxFaultEventB,
  // Framer receive streams
  input  wire logic        rxPushA,
  input  wire logic [7:0]  rxDataA,
  input  wire logic        rxMsgDoneA,
  input  wire logic        rxPushB,
  input  wire logic [7:0]  rxDataB,
  input  wire logic        rxMsgDoneB,
  // Link setup sequencer of line A
  input  wire logic        linkSetupDone,
  input  wire logic        linkSetupOk,
  input  wire logic [1:0]  linkSetupRate,
  // Indicator pins
  output logic             rxFaultPinA,
  output logic             rxFaultPinB,
  output logic             rxAvailPinA,
  output logic             rxAvailPinB,
  // Line A control outputs
  output logic [1:0]       lineARate,
  output logic             lineALinkSetupStart,
  output logic [4:0]       lineAAuxCtrl,
  output logic [11:0]      lineARateKbps10,
  output logic             lineARateFail
);

  fimfl_rxq_if qa ();
  fimfl_rxq_if qb ();

  fimfl_rx_queue u_queueA (.clock(clock), .rst_n(rst_n), .q(qa.queue));
  fimfl_rx_queue u_queueB (.clock(clock), .rst_n(rst_n), .q(qb.queue));

  logic             clkMeta_ff, clkSync_ff, clkPrev_ff;
  logic             selMeta_ff, selSync_ff;
  logic             mosiMeta_ff, mosiSync_ff;
  fimfl_spi_state_t state_ff,    nxt_state;
  logic [3:0]       bitCnt_ff,   nxt_bitCnt;
  logic [7:0]       shiftIn_ff,  nxt_shiftIn;
  logic [7:0]       shiftOut_ff, nxt_shiftOut;
  logic [7:0]       cmd_ff,      nxt_cmd;
  logic             miso_ff,     nxt_miso;
  logic             misoOeN_ff,  nxt_misoOeN;
  logic [7:0]       mask_ff,     nxt_mask;
  logic [7:0]       line_ff,     nxt_line;
  logic [7:0]       evt_ff,      nxt_evt;
  logic [7:0]       lvlA_ff,     lvlB_ff;
  logic             emptyPrevA_ff, emptyPrevB_ff;
  logic             irqOeN_ff;
  logic [11:0]      kbps_ff,     nxt_kbps;
  logic             rateFail_ff;
  logic             sclkRise, sclkFall;
  logic [7:0]       cmdNow, rdValue, evtSet, evtClr;
  logic             rdStrobe, wrStrobe;
  logic             availSetA, availSetB;

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clkMeta_ff  <= 1'b0;
      clkSync_ff  <= 1'b0;
      clkPrev_ff  <= 1'b0;
      selMeta_ff  <= 1'b1;
      selSync_ff  <= 1'b1;
      mosiMeta_ff <= 1'b0;
      mosiSync_ff <= 1'b0;
    end else begin
      clkMeta_ff  <= spiClk;
      clkSync_ff  <= clkMeta_ff;
      clkPrev_ff  <= clkSync_ff;
      selMeta_ff  <= spiSelN;
      selSync_ff  <= selMeta_ff;
      mosiMeta_ff <= spiMosi;
      mosiSync_ff <= mosiMeta_ff;
    end
  end

  assign sclkRise = clkSync_ff && !clkPrev_ff;
  assign sclkFall = !clkSync_ff && clkPrev_ff;
  assign cmdNow   = {shiftIn_ff[6:0], mosiSync_ff};

  // Read mux for the register addressed by the command just taken
  always_comb begin
    case (cmdNow[4:0])
      ADDR_DATA_A:   rdValue = qa.popData;
      ADDR_DATA_B:   rdValue = qb.popData;
      ADDR_EVENTS:   rdValue = evt_ff;
      ADDR_IRQ_MASK: rdValue = mask_ff;
      ADDR_LVL_A:    rdValue = lvlA_ff;
      ADDR_LVL_B:    rdValue = lvlB_ff;
      ADDR_LINE_A:   rdValue = line_ff;
      default:       rdValue = BYTE_ZERO;
    endcase
  end

  // Serial frame: command byte, then one data byte in or out
  always_comb begin
    nxt_state    = state_ff;
    nxt_bitCnt   = bitCnt_ff;
    nxt_shiftIn  = shiftIn_ff;
    nxt_shiftOut = shiftOut_ff;
    nxt_cmd      = cmd_ff;
    nxt_miso     = miso_ff;
    nxt_misoOeN  = selSync_ff;
    rdStrobe     = 1'b0;
    wrStrobe     = 1'b0;
    if (selSync_ff) begin
      nxt_state  = SPI_IDLE;
      nxt_bitCnt = SPI_CNT_ZERO;
    end else begin
      case (state_ff)
        SPI_IDLE: begin
          nxt_state = SPI_CMD;
        end
        SPI_CMD: begin
          if (sclkRise) begin
            nxt_shiftIn = cmdNow;
            nxt_bitCnt  = 4'(bitCnt_ff + 1'b1);
            if (bitCnt_ff == SPI_LAST_BIT) begin
              nxt_cmd      = cmdNow;
              nxt_bitCnt   = SPI_CNT_ZERO;
              nxt_state    = SPI_DATA;
              rdStrobe     = !cmdNow[CMD_WRITE_BIT];
              nxt_shiftOut = cmdNow[CMD_WRITE_BIT] ? BYTE_ZERO : rdValue;
            end
          end
        end
        SPI_DATA: begin
          if (sclkFall) begin
            nxt_miso     = shiftOut_ff[7];
            nxt_shiftOut = {shiftOut_ff[6:0], 1'b0};
          end
          if (sclkRise) begin
            nxt_shiftIn = cmdNow;
            nxt_bitCnt  = 4'(bitCnt_ff + 1'b1);
            if (bitCnt_ff == SPI_LAST_BIT) begin
              wrStrobe  = cmd_ff[CMD_WRITE_BIT];
              nxt_state = SPI_HOLD;
            end
          end
        end
        SPI_HOLD: begin
          nxt_state = SPI_HOLD;
        end
        default: begin
          nxt_state = SPI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= SPI_IDLE;
      bitCnt_ff   <= SPI_CNT_ZERO;
      shiftIn_ff  <= BYTE_ZERO;
      shiftOut_ff <= BYTE_ZERO;
      cmd_ff      <= BYTE_ZERO;
      miso_ff     <= 1'b0;
      misoOeN_ff  <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      bitCnt_ff   <= nxt_bitCnt;
      shiftIn_ff  <= nxt_shiftIn;
      shiftOut_ff <= nxt_shiftOut;
      cmd_ff      <= nxt_cmd;
      miso_ff     <= nxt_miso;
      misoOeN_ff  <= nxt_misoOeN;
    end
  end

  // Queue hookup; reading a data register pops its queue
  assign qa.push     = rxPushA;
  assign qa.pushData = rxDataA;
  assign qa.msgDone  = rxMsgDoneA;
  assign qa.pop      = rdStrobe && (cmdNow[4:0] == ADDR_DATA_A);
  assign qb.push     = rxPushB;
  assign qb.pushData = rxDataB;
  assign qb.msgDone  = rxMsgDoneB;
  assign qb.pop      = rdStrobe && (cmdNow[4:0] == ADDR_DATA_B);
  assign availSetA   = emptyPrevA_ff && !qa.empty;
  assign availSetB   = emptyPrevB_ff && !qb.empty;

  // Events, mask, line A control and rate decode
  always_comb begin
    evtSet = {supplyFaultEvent, linkSetupDone, txFaultEventB, txFaultEventA,
              rxFaultEventB, rxFaultEventA, availSetB, availSetA};
    evtClr = BYTE_ZERO;
    if (rdStrobe && cmdNow[4:0] == ADDR_EVENTS) begin
      evtClr = EVT_CLR_ON_READ;
    end
    evtClr[BIT_AVL_A] = qa.pop;
    evtClr[BIT_AVL_B] = qb.pop;
    nxt_evt  = (evt_ff & ~evtClr) | evtSet; // Set wins over clear
    nxt_mask = mask_ff;
    nxt_line = line_ff;
    if (wrStrobe && cmd_ff[4:0] == ADDR_IRQ_MASK) begin
      nxt_mask = cmdNow;
    end
    if (wrStrobe && cmd_ff[4:0] == ADDR_LINE_A) begin
      nxt_line = cmdNow;
    end
    if (linkSetupDone) begin
      nxt_line[RATE_HI:RATE_LO] = linkSetupOk ? linkSetupRate
                                              : RATE_FAIL;
      nxt_line[LINK_SETUP]      = 1'b0;
    end
    case (line_ff[RATE_HI:RATE_LO])
      RATE_COM1: nxt_kbps = KBPS10_COM1;
      RATE_COM2: nxt_kbps = KBPS10_COM2;
      default:   nxt_kbps = KBPS10_COM3;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      evt_ff        <= EVENTS_RST;
      mask_ff       <= IRQ_MASK_RST;
      line_ff       <= LINE_A_RST;
      lvlA_ff       <= LVL_A_RST;
      lvlB_ff       <= LVL_B_RST;
      emptyPrevA_ff <= 1'b1;
      emptyPrevB_ff <= 1'b1;
      irqOeN_ff     <= 1'b1;
      kbps_ff       <= KBPS10_COM3;
      rateFail_ff   <= 1'b1;
    end else begin
      evt_ff        <= nxt_evt;
      mask_ff       <= nxt_mask;
      line_ff       <= nxt_line;
      lvlA_ff       <= qa.level;
      lvlB_ff       <= qb.level;
      emptyPrevA_ff <= qa.empty;
      emptyPrevB_ff <= qb.empty;
      irqOeN_ff     <= ~|(evt_ff & mask_ff);
      kbps_ff       <= nxt_kbps;
      rateFail_ff   <= line_ff[RATE_HI:RATE_LO] == RATE_FAIL;
    end
  end

  assign spiMiso             = miso_ff;
  assign spiMisoOeN          = misoOeN_ff;
  assign irqOut              = 1'b0;
  assign irqOeN              = irqOeN_ff;
  assign rxFaultPinA         = evt_ff[BIT_RXF_A];
  assign rxFaultPinB         = evt_ff[BIT_RXF_B];
  assign rxAvailPinA         = evt_ff[BIT_AVL_A];
  assign rxAvailPinB         = evt_ff[BIT_AVL_B];
  assign lineARate           = line_ff[RATE_HI:RATE_LO];
  assign lineALinkSetupStart = line_ff[LINK_SETUP];
  assign lineAAuxCtrl        = line_ff[AUX_HI:0];
  assign lineARateKbps10     = kbps_ff;
  assign lineARateFail       = rateFail_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence setup_ok_s;
    linkSetupDone && linkSetupOk;
  endsequence
  sequence rate_seen_s;
    ##1 lineARate == $past(linkSetupRate) ##1 !lineARateFail;
  endsequence

  supply_gate_a : assert property ((evt_ff[7] && mask_ff[7]) |=>
    !irqOeN) else $error("supply fault did not raise the interrupt");
  wake_gate_a : assert property ((evt_ff[6] && mask_ff[6]) |=>
    !irqOeN) else $error("wake-up event did not raise the interrupt");
  txb_gate_a : assert property ((evt_ff[5] && mask_ff[5]) |=>
    !irqOeN) else $error("tx fault B did not raise the interrupt");
  txa_gate_a : assert property ((evt_ff[4] && mask_ff[4]) |=>
    !irqOeN) else $error("tx fault A did not raise the interrupt");
  rx_fault_gate_a : assert property (|(evt_ff[3:2] & mask_ff[3:2])
    |=> !irqOeN) else $error("rx fault did not raise the interrupt");
  fault_pin_a : assert property ((rxFaultEventA && !mask_ff[2])
    |=> rxFaultPinA) else $error("rx fault pin followed the mask");
  avail_gate_a : assert property (|(evt_ff[1:0] & mask_ff[1:0])
    |=> !irqOeN) else $error("data ready did not raise the interrupt");
  avail_pin_a : assert property ((availSetA && !mask_ff[0])
    |=> rxAvailPinA) else $error("data ready pin followed the mask");
  line_write_a : assert property ((wrStrobe && cmd_ff[4:0] == ADDR_LINE_A
    && !linkSetupDone) |=> lineARate == $past(cmdNow[7:6]))
    else $error("line A rate field did not take the write");
  setup_rate_a : assert property (setup_ok_s |->
    rate_seen_s or (##1 lineARate == RATE_FAIL))
    else $error("detected rate was not stored");
  rate_decode_a : assert property ((lineARate == RATE_COM2) |=>
    lineARateKbps10 == KBPS10_COM2) else $error("rate decode wrong");
  avail_set_a : assert property ($fell(qa.empty) |=>
    evt_ff[BIT_AVL_A]) else $error("data ready A did not set");
  irq_or_a : assert property (irqOeN ==
    !$past(|(evt_ff & mask_ff))) else $error("interrupt is not the OR");

endmodule : fimfl_top
`default_nettype wire

// File: testbench/fimfl_host_model.sv
// Host controller model that runs frames on the serial register port
`timescale 1ns/1ps
`default_nettype none
module fimfl_host_model (
  // Clock
  input  wire logic clock,
  // Serial register port
  output logic      spiClk,
  output logic      spiSelN,
  output logic      spiMosi,
  input  wire logic spiMiso,
  input  wire logic spiMisoOeN
);
  // Port idle at time zero
  initial begin
    spiClk = 1'b0;
    spiSelN = 1'b1;
    spiMosi = 1'b0;
  end

  // One command and one data byte, six clocks per serial half period
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(negedge clock) spiSelN = 1'b0;
    for (int i = 0; i < 16; i++) begin
      spiMosi = sh[15 - i];
      repeat (6) @(negedge clock);
      if (i > 7) rd = {rd[6:0], spiMisoOeN ? ~rd[0] : spiMiso};
      spiClk = 1'b1;
      repeat (6) @(negedge clock);
      spiClk = 1'b0;
    end
    spiSelN = 1'b1;
    spiMosi = ~spiMosi; // Released data line keeps no stale bit
    repeat (6) @(negedge clock);
  endtask : xfer
endmodule : fimfl_host_model
`default_nettype wire

// File: testbench/framer_irq_mask_fifo_level_tb_top.sv
// Self-checking bench for the interrupt mask and queue level registers
`timescale 1ns/1ps
`default_nettype none
module framer_irq_mask_fifo_level_tb_top import fimfl_pkg::*;;
  // Stimulus, observed pins and model state
  logic        clock, rst_n, spiClk, spiSelN, spiMosi, spiMiso, spiMisoOeN;
  logic        irqOut, irqOeN, linkSetupOk, lineALinkSetupStart;
  logic        lineARateFail;
  logic [7:0]  evt, flags, mask, v;
  logic [7:0]  seed = 8'h58;
  logic [1:0]  push, msgDone, linkSetupRate, lineARate;
  logic [7:0]  rxData [2];
  logic [3:0]  pins;
  logic [4:0]  lineAAuxCtrl;
  logic [11:0] lineARateKbps10;
  int          failCount, samplesChecked, n;
  byte unsigned expQ[$];
  wire logic   irqLine = irqOeN | irqOut; // Pulled up while released

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Block under test and host partner
  fimfl_top dut (
    .clock, .rst_n, .spiClk, .spiSelN, .spiMosi, .spiMiso, .spiMisoOeN,
    .irqOut, .irqOeN, .supplyFaultEvent(evt[7]), .txFaultEventA(evt[4]),
    .txFaultEventB(evt[5]), .rxFaultEventA(evt[2]), .rxFaultEventB(evt[3]),
    .rxPushA(push[0]), .rxDataA(rxData[0]), .rxMsgDoneA(msgDone[0]),
    .rxPushB(push[1]), .rxDataB(rxData[1]), .rxMsgDoneB(msgDone[1]),
    .linkSetupDone(evt[6]), .linkSetupOk, .linkSetupRate,
    .rxFaultPinA(pins[2]), .rxFaultPinB(pins[3]), .rxAvailPinA(pins[0]),
    .rxAvailPinB(pins[1]), .lineARate, .lineALinkSetupStart, .lineAAuxCtrl,
    .lineARateKbps10, .lineARateFail);
  fimfl_host_model host (
    .clock, .spiClk, .spiSelN, .spiMosi, .spiMiso, .spiMisoOeN);

  // Pseudo-random byte source
  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_step

  // Compare one observed value with the model's expectation
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic closeOut();
    if (failCount == 0 && samplesChecked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : closeOut

  // Register reads and writes through the host model
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    host.xfer({3'h0, a}, 8'h00, d);
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer({3'h4, a}, d, unused);
  endtask : wr

  // Interrupt line and indicator pins against the model
  task automatic check_state();
    repeat (4) @(negedge clock);
    check("irq", 16'(irqLine), 16'(~|(flags & mask)));
    check("pins", 16'(pins), 16'(flags[3:0]));
  endtask : check_state

  // Decoded line A rate against a code
  task automatic check_rate(input logic [1:0] r);
    logic [11:0] k;
    k = r == RATE_COM1 ? KBPS10_COM1 :
        r == RATE_COM2 ? KBPS10_COM2 : KBPS10_COM3;
    check("rate", 16'(lineARate), 16'(r));
    check("kbps", 16'(lineARateKbps10), 16'(k));
    check("rateFail", 16'(lineARateFail), 16'(r == RATE_FAIL));
  endtask : check_rate

  // Main sequence
  initial begin
    logic [1:0] r;
    logic [4:0] ta [3];
    {rst_n, evt, push, msgDone, linkSetupOk, linkSetupRate} = '0;
    rxData = '{8'h00, 8'h00};
    {flags, mask} = 16'h0000;
    ta = '{ADDR_IRQ_MASK, ADDR_LVL_B, 5'h1F};
    repeat (4) @(negedge clock);
    check("irqRst", 16'(irqOeN), 16'h0001);
    check_rate(RATE_FAIL);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int a = 3; a < 7; a++) begin
      rd(5'(a), v);
      check("rstVal", 16'(v), 16'h0000);
    end
    for (int i = 0; i < 3; i++) begin
      wr(ta[i], 8'hA5);
      rd(ta[i], v);
      check("access", 16'(v), i == 0 ? 16'h00A5 : 16'h0000);
    end
    for (int b = 7; b >= 0; b--) begin
      mask = ~(8'h01 << b);
      wr(ADDR_IRQ_MASK, mask);
      seed = lfsr_step(seed);
      if (b == 6) begin
        wr(ADDR_LINE_A, 8'h20);
        {linkSetupOk, linkSetupRate} = seed[2:0];
      end
      if (b > 1) begin
        @(negedge clock) evt[b] = 1'b1;
        @(negedge clock) evt[b] = 1'b0;
      end else begin
        n = int'(seed[2:0]) + 1;
        for (int k = 0; k < n; k++) begin
          @(negedge clock) push[b] = 1'b1;
          seed = lfsr_step(seed);
          rxData[b] = seed;
          expQ.push_back(seed);
        end
        @(negedge clock) push[b] = 1'b0;
        msgDone[b] = 1'b1;
        @(negedge clock) msgDone[b] = 1'b0;
      end
      flags[b] = 1'b1;
      check_state();
      mask = 8'hFF;
      wr(ADDR_IRQ_MASK, mask);
      check_state();
      rd(ADDR_EVENTS, v);
      check("events", 16'(v), 16'(flags));
      flags[7:2] = 6'h00;
      if (b == 6) begin
        r = linkSetupOk ? linkSetupRate : RATE_FAIL;
        check_rate(r);
        rd(ADDR_LINE_A, v);
        check("lineA", 16'(v), 16'({r, 6'h00}));
      end
      if (b < 2) begin
        rd(ADDR_LVL_A + 5'(b), v);
        check("level", 16'(v), 16'(n));
        rd(ADDR_DATA_A + 5'(b), v);
        check("lenByte", 16'(v), 16'(n));
        flags[b] = 1'b0;
        while (expQ.size() > 0) begin
          rd(ADDR_DATA_A + 5'(b), v);
          check("data", 16'(v), 16'(expQ.pop_front()));
        end
        rd(ADDR_LVL_A + 5'(b), v);
        check("drained", 16'(v), 16'h0000);
      end
      check_state();
    end
    for (int c = 0; c < 4; c++) begin
      seed = lfsr_step(seed);
      wr(ADDR_LINE_A, {2'(c), seed[5:0]});
      repeat (2) @(negedge clock);
      check_rate(2'(c));
      check("ctl", 16'({lineALinkSetupStart, lineAAuxCtrl}), 16'(seed[5:0]));
    end
    closeOut();
  end

  // Cut a hung run short
  initial begin
    repeat (50000) @(posedge clock);
    failCount++;
    closeOut();
  end
endmodule : framer_irq_mask_fifo_level_tb_top
`default_nettype wire
